// *** design/cpl_pkg.sv ***
// Package of constants and types for the configuration port pin logic
package cpl_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 20;  // Parallel EEPROM address width
  localparam int DATA_W = 8;   // Parallel configuration byte width
  localparam int MODE_W = 3;   // Mode select width
  localparam int USER_W = 16;  // User I/O count behind the global tri-state

  // ----------------------------------------
  // Mode select encodings (arbitrary codes; any other code captures nothing)
  // ----------------------------------------
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
  localparam logic [2:0] MODE_MASTER_PAR = 3'h1;
  localparam logic [2:0] MODE_PERIPHERAL = 3'h3;
  localparam logic [2:0] MODE_SLAVE_PAR = 3'h6;

  // ----------------------------------------
  // Reset values and bit positions
  // ----------------------------------------
  localparam logic [19:0] ADDR_RESET = 20'h0_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int BYTE_MSB = 7;  // Chain output carries only this bit of each byte in parallel modes

  // Loader phases
  typedef enum logic [1:0] {
    CPL_INIT,
    CPL_CONFIG,
    CPL_DONE
  } cpl_state_t;

endpackage

// *** design/cpl_config_port.sv ***
// Configuration port pin logic: error signalling, selects, address, data and chain output
// ----------------------------------------
// Configuration port top module
// ----------------------------------------
// How it works
// - Drive error low on CRC or preamble fault
// - Error holds init until program and reset high
// - Error returns high once configuration restarts
// - Pull-up on error pin during configuration
// - Global tri-state floats user I/O, pulls down
// - Peripheral select: select_low_n, write low, select_high high
// - Master parallel drives 20-bit EEPROM address
// - Parallel modes take bytes on data bus
// - Serial chain output feeds next device
// - Chain output changes on clock falling edge
// - Selects become user I/O after configuration
// - Serial input sampled with configuration clock
// - Progress outputs high and low while configuring
module cpl_config_port #(
  parameter int USER_N = cpl_pkg::USER_W
) (
  input wire logic SYS_CLK,                            // System clock, 125 MHz
  input wire logic NRST,                               // Asynchronous reset, active low
  input wire logic PROGRAM_N,                          // Program request pin, active low
  input wire logic RESET_N,                            // Device reset pin, active low
  input wire logic [cpl_pkg::MODE_W-1:0] CFG_MODE_SELECT, // Mode select pins
  input wire logic CFG_CLK,                            // Configuration clock pin
  input wire logic SERIAL_IN,                          // Serial input, data bit 0 in parallel modes
  input wire logic [cpl_pkg::DATA_W-1:0] DATA_IN,      // Parallel data pins
  input wire logic SELECT_LOW_N,                       // Peripheral chip select, active low
  input wire logic SELECT_HIGH,                        // Peripheral chip select, active high
  input wire logic WRITE_N,                            // Peripheral write strobe, active low
  input wire logic GLOBAL_TRISTATE,                    // Global tri-state, active high
  input wire logic STREAM_ERROR,                       // Frame checker: CRC or preamble fault
  input wire logic STREAM_DONE,                        // Frame checker: configuration complete
  input wire logic [USER_N-1:0] USER_OUT,              // User logic output values
  input wire logic [USER_N-1:0] USER_OE,               // User logic output enables
  output logic [USER_N-1:0] USER_PIN_OUT,              // User pin output values
  output logic [USER_N-1:0] USER_PIN_OE,               // User pin output enables
  output logic [USER_N-1:0] USER_PULLDOWN,             // User pin pull-down enables
  output logic CFG_ERR_OUT,                            // Error pin output value
  output logic CFG_ERR_OE,                             // Error pin output enable
  output logic CFG_ERR_PULLUP,                         // Error pin pull-up enable
  output logic [cpl_pkg::ADDR_W-1:0] EEPROM_ADDR,      // EEPROM address pins
  output logic EEPROM_ADDR_OE,                         // EEPROM address output enable
  output logic [cpl_pkg::DATA_W-1:0] CFG_BYTE,         // Captured configuration byte
  output logic CFG_BYTE_VALID,                         // One-cycle pulse with each byte
  output logic CHAIN_OUT,                              // Serial chain output
  output logic CHAIN_OE,                               // Chain output enable
  output logic CFG_ACTIVE,                             // High during configuration
  output logic CFG_ACTIVE_N,                           // Low during configuration
  output logic PERIPH_SELECTED,                        // Peripheral select decode
  output logic SELECT_PINS_USER                        // Select pins released to user I/O
);
  import cpl_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 17 + DATA_W;
  logic [SYNC_W-1:0] sync_a;   // First stage, read only by the second stage
  logic [SYNC_W-1:0] sync_b;   // Second stage, safe to use
  logic prog_n_s, rst_n_s, cclk_s, sin_s, sel_lo_n_s, sel_hi_s, wrn_s, gts_s, err_s, done_s;
  logic [MODE_W-1:0] mode_s;
  logic [DATA_W-1:0] data_s;

  // Two flops on every pin and on the frame checker's flags
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {PROGRAM_N, RESET_N, CFG_CLK, SERIAL_IN, SELECT_LOW_N, SELECT_HIGH, WRITE_N,
                 GLOBAL_TRISTATE, STREAM_ERROR, STREAM_DONE, CFG_MODE_SELECT, 4'h0, DATA_IN};
      sync_b <= sync_a;
    end
  end

  assign {prog_n_s, rst_n_s, cclk_s, sin_s, sel_lo_n_s, sel_hi_s, wrn_s, gts_s, err_s, done_s,
          mode_s} = sync_b[SYNC_W-1:DATA_W+4];
  assign data_s = sync_b[DATA_W-1:0];

  // ----------------------------------------
  // Clock edge detection
  // ----------------------------------------
  logic cclk_d;     // Previous synchronised clock level
  logic cclk_rise;  // Rising edge of configuration clock
  logic cclk_fall;  // Falling edge of configuration clock

  // Delay the synchronised clock one cycle for edge finding
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cclk_d <= 1'b0;
    end else begin
      cclk_d <= cclk_s;
    end
  end

  assign cclk_rise = cclk_s & ~cclk_d;
  assign cclk_fall = ~cclk_s & cclk_d;

  // ----------------------------------------
  // Loader state
  // ----------------------------------------
  cpl_state_t state;       // Current phase
  cpl_state_t next_state;  // Next phase
  logic restart_ok;        // Program and reset both released high
  logic [MODE_W-1:0] mode; // Mode latched at the start of configuration
  logic serial_mode;       // Serial modes take one bit per clock

  assign restart_ok = prog_n_s & rst_n_s;
  assign serial_mode = (mode == MODE_MASTER_SERIAL) || (mode == MODE_SLAVE_SERIAL);

  // Phase decisions; an error during configuration pulls back to init
  always_comb begin
    next_state = state;
    unique case (state)
      CPL_INIT: begin
        if (restart_ok) begin
          next_state = CPL_CONFIG;
        end
      end
      CPL_CONFIG: begin
        if (err_s) begin
          next_state = CPL_INIT;
        end else if (done_s) begin
          next_state = CPL_DONE;
        end
      end
      CPL_DONE: begin
        if (!prog_n_s) begin
          next_state = CPL_INIT;  // Reprogram request
        end
      end
    endcase
  end

  // Phase register
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= CPL_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Mode is caught on entry to configuration, so pins must be stable before it
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      mode <= MODE_MASTER_SERIAL;
    end else if (state == CPL_INIT && next_state == CPL_CONFIG) begin
      mode <= mode_s;
    end
  end

  // ----------------------------------------
  // Error pin
  // ----------------------------------------
  logic err_flag;  // Error seen, held until restart

  // Set on a fault while configuring; cleared only when configuration restarts
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      err_flag <= 1'b0;
    end else if (state == CPL_CONFIG && err_s) begin
      err_flag <= 1'b1;
    end else if (state == CPL_INIT && restart_ok) begin
      err_flag <= 1'b0;
    end
  end

  // Open-drain style: drive low on error, otherwise float, on the pull-up except once done
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      CFG_ERR_OUT <= 1'b0;
      CFG_ERR_OE <= 1'b0;
      CFG_ERR_PULLUP <= 1'b1;
    end else begin
      CFG_ERR_OUT <= 1'b0;
      CFG_ERR_OE <= err_flag;
      CFG_ERR_PULLUP <= (next_state != CPL_DONE);
    end
  end

  // ----------------------------------------
  // Progress outputs and select decode
  // ----------------------------------------
  // Progress pins follow the phase one cycle late
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      CFG_ACTIVE <= 1'b0;
      CFG_ACTIVE_N <= 1'b1;
      SELECT_PINS_USER <= 1'b0;
    end else begin
      CFG_ACTIVE <= (state == CPL_CONFIG);
      CFG_ACTIVE_N <= (state != CPL_CONFIG);
      SELECT_PINS_USER <= (state == CPL_DONE);
    end
  end

  logic periph_sel;  // Select decode, only meaningful in peripheral mode
  assign periph_sel = (state == CPL_CONFIG) && (mode == MODE_PERIPHERAL) &&
                      !sel_lo_n_s && !wrn_s && sel_hi_s;
  assign PERIPH_SELECTED = periph_sel;

  // ----------------------------------------
  // Parallel byte capture and EEPROM address
  // ----------------------------------------
  logic sel_d;     // Previous select, to take one byte per strobe
  logic take_par;  // Take a parallel byte this cycle

  always_comb begin
    take_par = 1'b0;
    if (state == CPL_CONFIG) begin
      unique case (mode)
        MODE_MASTER_PAR, MODE_SLAVE_PAR: take_par = cclk_rise;
        MODE_PERIPHERAL: take_par = periph_sel & ~sel_d;
        default: take_par = 1'b0;                               // Serial modes
      endcase
    end
  end

  // Remember the select to find its leading edge
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sel_d <= 1'b0;
    end else begin
      sel_d <= periph_sel;
    end
  end

  logic [2:0] bit_cnt;          // Serial bits gathered
  logic [DATA_W-1:0] ser_shift; // Serial gather register

  // Serial bits sampled on clock rising edges, MSB first
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      bit_cnt <= 3'h0;
      ser_shift <= BYTE_RESET;
    end else if (state != CPL_CONFIG) begin
      bit_cnt <= 3'h0;
    end else if (serial_mode && cclk_rise) begin
      ser_shift <= {ser_shift[DATA_W-2:0], sin_s};
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Byte output register; in parallel modes bit 0 is the serial pin
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      CFG_BYTE <= BYTE_RESET;
      CFG_BYTE_VALID <= 1'b0;
    end else begin
      CFG_BYTE_VALID <= 1'b0;
      if (take_par) begin
        CFG_BYTE <= {data_s[DATA_W-1:1], sin_s};
        CFG_BYTE_VALID <= 1'b1;
      end else if (state == CPL_CONFIG && serial_mode && cclk_rise && bit_cnt == 3'h7) begin
        CFG_BYTE <= {ser_shift[DATA_W-2:0], sin_s};
        CFG_BYTE_VALID <= 1'b1;
      end
    end
  end

  // Address steps after each byte; restarts from zero on every new attempt
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      EEPROM_ADDR <= ADDR_RESET;
      EEPROM_ADDR_OE <= 1'b0;
    end else begin
      EEPROM_ADDR_OE <= (state == CPL_CONFIG) && (mode == MODE_MASTER_PAR);
      if (state != CPL_CONFIG) begin
        EEPROM_ADDR <= ADDR_RESET;
      end else if (mode == MODE_MASTER_PAR && take_par) begin
        EEPROM_ADDR <= EEPROM_ADDR + 20'h0_0001;
      end
    end
  end

  // ----------------------------------------
  // Serial chain output
  // ----------------------------------------
  // Bits pass through to the next device, updated only on falling edges
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      CHAIN_OUT <= 1'b1;
      CHAIN_OE <= 1'b0;
    end else begin
      CHAIN_OE <= (state == CPL_CONFIG);
      if (state == CPL_CONFIG && cclk_fall) begin
        CHAIN_OUT <= serial_mode ? ser_shift[0] : CFG_BYTE[BYTE_MSB];
      end
    end
  end

  // ----------------------------------------
  // User I/O and global tri-state
  // ----------------------------------------
  // Tri-state overrides user enables and turns on pull-downs
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      USER_PIN_OUT <= '0;
      USER_PIN_OE <= '0;
      USER_PULLDOWN <= '0;
    end else begin
      USER_PIN_OUT <= USER_OUT;
      USER_PIN_OE <= (gts_s || state != CPL_DONE) ? '0 : USER_OE;
      USER_PULLDOWN <= gts_s ? '1 : '0;
    end
  end

endmodule

// *** testbench/cpl_port_assertions.sv ***
// Checker for the configuration port pin behaviour
module cpl_port_assertions #(
  parameter int USER_N = 16
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PROGRAM_N,
  input wire logic RESET_N,
  input wire logic CFG_CLK,
  input wire logic SELECT_LOW_N,
  input wire logic SELECT_HIGH,
  input wire logic WRITE_N,
  input wire logic GLOBAL_TRISTATE,
  input wire logic STREAM_ERROR,
  input wire logic [USER_N-1:0] USER_PIN_OE,
  input wire logic [USER_N-1:0] USER_PULLDOWN,
  input wire logic CFG_ERR_OUT,
  input wire logic CFG_ERR_OE,
  input wire logic [cpl_pkg::ADDR_W-1:0] EEPROM_ADDR,
  input wire logic EEPROM_ADDR_OE,
  input wire logic CFG_BYTE_VALID,
  input wire logic CHAIN_OUT,
  input wire logic CHAIN_OE,
  input wire logic CFG_ACTIVE,
  input wire logic CFG_ACTIVE_N,
  input wire logic PERIPH_SELECTED,
  input wire logic SELECT_PINS_USER
);
  // ----------------------------------------
  // Properties on the system clock
  // ----------------------------------------
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  a_err_low: assert property (CFG_ERR_OE |-> !CFG_ERR_OUT)
    else $error("error pin driven high");
  a_err_on_fault: assert property ($rose(STREAM_ERROR) && CFG_ACTIVE |-> ##[1:6] CFG_ERR_OE)
    else $error("fault not flagged");
  a_restart_needs_pins: assert property ($rose(CFG_ACTIVE) |-> $past(PROGRAM_N, 4) && $past(RESET_N, 4))
    else $error("restart without both pins high");
  a_err_pin_clears: assert property (CFG_ERR_OE && PROGRAM_N && RESET_N && !STREAM_ERROR |-> ##[1:8] !CFG_ERR_OE)
    else $error("error pin stuck");
  // Sync flops add latency, so the float is judged after five steady cycles
  a_tristate_float: assert property (GLOBAL_TRISTATE [*5] |-> !(|USER_PIN_OE) && (&USER_PULLDOWN))
    else $error("user pins not floated");
  a_select_decode: assert property (PERIPH_SELECTED |-> !$past(SELECT_LOW_N, 2) && !$past(WRITE_N, 2) && $past(SELECT_HIGH, 2))
    else $error("select without full decode");
  a_addr_step: assert property ($rose(CFG_BYTE_VALID) && EEPROM_ADDR_OE |-> EEPROM_ADDR == $past(EEPROM_ADDR) + 20'h0_0001)
    else $error("address did not step");
  a_byte_pulse: assert property (CFG_BYTE_VALID |-> CFG_ACTIVE ##1 !CFG_BYTE_VALID)
    else $error("byte outside configuration");
  a_chain_on_fall: assert property (CHAIN_OE && $past(CHAIN_OE) && $changed(CHAIN_OUT) |-> !$past(CFG_CLK, 3))
    else $error("chain changed after a rise");
  a_user_release: assert property (SELECT_PINS_USER |-> !CFG_ACTIVE)
    else $error("pins released while configuring");
  a_active_pair: assert property (CFG_ACTIVE != CFG_ACTIVE_N)
    else $error("progress outputs disagree");
  c_fault: cover property ($rose(CFG_ERR_OE));
  c_addr_byte: cover property (CFG_BYTE_VALID && EEPROM_ADDR_OE);
  c_release: cover property ($rose(SELECT_PINS_USER));
endmodule

bind cpl_config_port cpl_port_assertions #(.USER_N(USER_N)) u_chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .PROGRAM_N(PROGRAM_N), .RESET_N(RESET_N), .CFG_CLK(CFG_CLK),
  .SELECT_LOW_N(SELECT_LOW_N), .SELECT_HIGH(SELECT_HIGH), .WRITE_N(WRITE_N), .GLOBAL_TRISTATE(GLOBAL_TRISTATE),
  .STREAM_ERROR(STREAM_ERROR), .USER_PIN_OE(USER_PIN_OE), .USER_PULLDOWN(USER_PULLDOWN), .CFG_ERR_OUT(CFG_ERR_OUT),
  .CFG_ERR_OE(CFG_ERR_OE), .EEPROM_ADDR(EEPROM_ADDR), .EEPROM_ADDR_OE(EEPROM_ADDR_OE),
  .CFG_BYTE_VALID(CFG_BYTE_VALID), .CHAIN_OUT(CHAIN_OUT), .CHAIN_OE(CHAIN_OE), .CFG_ACTIVE(CFG_ACTIVE),
  .CFG_ACTIVE_N(CFG_ACTIVE_N), .PERIPH_SELECTED(PERIPH_SELECTED), .SELECT_PINS_USER(SELECT_PINS_USER)
);

// *** testbench/cpl_far_side.sv ***
// Far-side model: source of configuration clock, data and peripheral selects
module cpl_far_side (
  output logic CFG_CLK,
  output logic SERIAL_IN,
  output logic [cpl_pkg::DATA_W-1:0] DATA_IN,
  output logic SELECT_LOW_N,
  output logic SELECT_HIGH,
  output logic WRITE_N
);
  timeunit 1ns;
  timeprecision 100ps;
  import cpl_pkg::*;
  initial begin
    CFG_CLK = 1'b0;
    SERIAL_IN = 1'b0;
    DATA_IN = 8'h00;
    SELECT_LOW_N = 1'b1;
    SELECT_HIGH = 1'b0;
    WRITE_N = 1'b1;
  end
  // One 125 ns clock period; the clock rests low between frames
  task automatic pulse();
    #62.5 CFG_CLK = 1'b1;
    #62.5 CFG_CLK = 1'b0;
  endtask
  // Sends one byte; the odd start offset keeps pin edges off the system clock
  task automatic send(input logic [2:0] mode, input logic [7:0] b, input logic sel);
    #1.3;
    if (mode == MODE_PERIPHERAL) begin
      DATA_IN = b;
      SERIAL_IN = b[0];
      #20 SELECT_LOW_N = 1'b0;
      WRITE_N = 1'b0;
      SELECT_HIGH = sel;
      #125 SELECT_LOW_N = 1'b1;
      WRITE_N = 1'b1;
      SELECT_HIGH = 1'b0;
      #125;
    end else if (mode == MODE_MASTER_SERIAL || mode == MODE_SLAVE_SERIAL) begin
      for (int i = 7; i >= 0; i--) begin
        SERIAL_IN = b[i]; // Set after a fall, steady at the rise
        pulse();
      end
    end else begin
      // Bus bit 0 is carried by the serial pin, so the bus copy is spoiled
      DATA_IN = {b[7:1], ~b[0]};
      SERIAL_IN = b[0];
      pulse();
    end
    // Lines past their hold time no longer show the old value
    SERIAL_IN = ~SERIAL_IN;
    DATA_IN = ~DATA_IN;
  endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the configuration port pin logic
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import cpl_pkg::*;
  logic SYS_CLK = 1'b0;
  logic NRST, PROGRAM_N, RESET_N, GLOBAL_TRISTATE, STREAM_ERROR, STREAM_DONE;
  logic [2:0] CFG_MODE_SELECT;
  logic [15:0] USER_OUT, USER_OE, USER_PIN_OUT, USER_PIN_OE, USER_PULLDOWN;
  wire logic CFG_CLK, SERIAL_IN, SELECT_LOW_N, SELECT_HIGH, WRITE_N;
  wire logic [7:0] DATA_IN;
  logic CFG_ERR_OUT, CFG_ERR_OE, CFG_ERR_PULLUP, EEPROM_ADDR_OE, CFG_BYTE_VALID, CHAIN_OUT, CHAIN_OE;
  logic CFG_ACTIVE, CFG_ACTIVE_N, PERIPH_SELECTED, SELECT_PINS_USER;
  logic [19:0] EEPROM_ADDR, a0;
  logic [7:0] CFG_BYTE, b;
  logic [7:0] exp_q[$]; // Bytes the port should capture, oldest first
  int bad_count = 0;
  int comparisons = 0;
  int seed = 14;
  logic [2:0] modes [5] = '{MODE_MASTER_SERIAL, MODE_MASTER_PAR, MODE_PERIPHERAL, MODE_SLAVE_PAR, MODE_SLAVE_SERIAL};
  always #4 SYS_CLK = ~SYS_CLK;
  cpl_config_port u_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .PROGRAM_N(PROGRAM_N), .RESET_N(RESET_N),
    .CFG_MODE_SELECT(CFG_MODE_SELECT), .CFG_CLK(CFG_CLK), .SERIAL_IN(SERIAL_IN), .DATA_IN(DATA_IN),
    .SELECT_LOW_N(SELECT_LOW_N), .SELECT_HIGH(SELECT_HIGH), .WRITE_N(WRITE_N), .GLOBAL_TRISTATE(GLOBAL_TRISTATE),
    .STREAM_ERROR(STREAM_ERROR), .STREAM_DONE(STREAM_DONE), .USER_OUT(USER_OUT), .USER_OE(USER_OE),
    .USER_PIN_OUT(USER_PIN_OUT), .USER_PIN_OE(USER_PIN_OE), .USER_PULLDOWN(USER_PULLDOWN),
    .CFG_ERR_OUT(CFG_ERR_OUT), .CFG_ERR_OE(CFG_ERR_OE), .CFG_ERR_PULLUP(CFG_ERR_PULLUP),
    .EEPROM_ADDR(EEPROM_ADDR), .EEPROM_ADDR_OE(EEPROM_ADDR_OE), .CFG_BYTE(CFG_BYTE), .CFG_BYTE_VALID(CFG_BYTE_VALID),
    .CHAIN_OUT(CHAIN_OUT), .CHAIN_OE(CHAIN_OE), .CFG_ACTIVE(CFG_ACTIVE), .CFG_ACTIVE_N(CFG_ACTIVE_N),
    .PERIPH_SELECTED(PERIPH_SELECTED), .SELECT_PINS_USER(SELECT_PINS_USER));
  cpl_far_side u_far (.CFG_CLK(CFG_CLK), .SERIAL_IN(SERIAL_IN), .DATA_IN(DATA_IN), .SELECT_LOW_N(SELECT_LOW_N),
    .SELECT_HIGH(SELECT_HIGH), .WRITE_N(WRITE_N));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("%0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bounded wait on progress, error pin or release; a run-out ends the test
  task automatic wait_sig(input int which, input logic v);
    logic [2:0] s;
    int i;
    i = 0;
    do begin
      @(negedge SYS_CLK);
      s = {SELECT_PINS_USER, CFG_ERR_OE, CFG_ACTIVE};
      i++;
    end while (s[which] !== v && i < 60);
    check("wait", 32'(s[which]), 32'(v));
    if (s[which] !== v) complete_run();
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask
  // Watcher: every valid pulse takes the oldest expected byte
  always @(negedge SYS_CLK) begin
    if (CFG_BYTE_VALID === 1'b1) begin
      if (exp_q.size() == 0) check("stray byte", 32'(CFG_BYTE), 32'hFFFF_FFFF);
      else check("byte", 32'(CFG_BYTE), 32'(exp_q.pop_front()));
    end
  end
  initial begin
    NRST = 1'b0;
    PROGRAM_N = 1'b0;
    RESET_N = 1'b1;
    GLOBAL_TRISTATE = 1'b0;
    STREAM_ERROR = 1'b0;
    STREAM_DONE = 1'b0;
    CFG_MODE_SELECT = MODE_MASTER_SERIAL;
    USER_OUT = 16'h0000;
    USER_OE = 16'h0000;
    repeat (8) @(posedge SYS_CLK);
    NRST <= 1'b1;
    foreach (modes[m]) begin
      @(posedge SYS_CLK);
      CFG_MODE_SELECT <= modes[m];
      PROGRAM_N <= 1'b1;
      RESET_N <= 1'b1;
      wait_sig(0, 1'b1);
      check("active low", 32'(CFG_ACTIVE_N), 32'h0);
      check("pull-up", 32'(CFG_ERR_PULLUP), 32'h1);
      check("chain oe", 32'(CHAIN_OE), 32'h1);
      check("addr oe", 32'(EEPROM_ADDR_OE), 32'(modes[m] == MODE_MASTER_PAR));
      a0 = EEPROM_ADDR;
      repeat (3) begin
        b = 8'($random(seed));
        exp_q.push_back(b);
        u_far.send(modes[m], b, 1'b1);
        cycles(8);
        if (modes[m] inside {MODE_MASTER_SERIAL, MODE_SLAVE_SERIAL}) check("chain", 32'(CHAIN_OUT), 32'(b[0]));
        if (modes[m] inside {MODE_MASTER_PAR, MODE_SLAVE_PAR}) check("chain", 32'(CHAIN_OUT), 32'(b[BYTE_MSB]));
      end
      if (modes[m] == MODE_MASTER_PAR) check("address", 32'(EEPROM_ADDR), 32'(a0 + 20'h0_0003));
      if (modes[m] == MODE_PERIPHERAL) u_far.send(modes[m], ~b, 1'b0); // High select left low: no byte
      // Fault with one restart pin low; the other pin takes the turn next mode
      @(posedge SYS_CLK);
      STREAM_ERROR <= 1'b1;
      if (m % 2) RESET_N <= 1'b0;
      else PROGRAM_N <= 1'b0;
      wait_sig(1, 1'b1);
      check("error level", 32'(CFG_ERR_OUT), 32'h0);
      check("init", 32'(CFG_ACTIVE), 32'h0);
      @(posedge SYS_CLK);
      STREAM_ERROR <= 1'b0;
      u_far.send(modes[m], b, 1'b1); // Ignored while held in init
      cycles(8);
      check("error held", 32'(CFG_ERR_OE), 32'h1);
      @(posedge SYS_CLK);
      PROGRAM_N <= 1'b1;
      RESET_N <= 1'b1;
      wait_sig(1, 1'b0);
      wait_sig(0, 1'b1);
      @(posedge SYS_CLK);
      STREAM_DONE <= 1'b1;
      USER_OE <= 16'($random(seed));
      USER_OUT <= 16'($random(seed));
      wait_sig(2, 1'b1);
      check("pull-up off", 32'(CFG_ERR_PULLUP), 32'h0);
      @(posedge SYS_CLK);
      GLOBAL_TRISTATE <= 1'b1;
      cycles(6);
      check("float", 32'(USER_PIN_OE), 32'h0);
      check("pull-down", 32'(USER_PULLDOWN), 32'h0000_FFFF);
      @(posedge SYS_CLK);
      GLOBAL_TRISTATE <= 1'b0;
      cycles(6);
      check("user oe", 32'(USER_PIN_OE), 32'(USER_OE));
      check("user out", 32'(USER_PIN_OUT), 32'(USER_OUT));
      @(posedge SYS_CLK);
      STREAM_DONE <= 1'b0;
      PROGRAM_N <= 1'b0;
      wait_sig(2, 1'b0);
    end
    check("pending bytes", 32'(exp_q.size()), 32'h0);
    complete_run();
  end
endmodule
